//--- hdl/dpd_core.sv
`timescale 1ns/1ps
`include "dpd_map.svh"
// Notes on behaviour
// - CKE low with DES enters power-down
// - pending row ops finish before low power
// - open banks give active, else precharge mode
// - buffers off except clock, CKE, reset, and ODT unless mode bit set
// - mode bit gates ODT buffer, RTT_NOM
// - park termination stays during power-down
// - receivers off only after tCPDED
// - DLL stays on; exit after tXP
// - reset low forces exit to reset
// - CKE high with DES exits; command tXP later
// - no RTT_NOM for ODT from tANPD on; here only with the mode bit set, cut from CKE low
// - self refresh exit is CKE rise with DES or NOP
module dpd_core
  import dpd_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // device pins as sampled
  input  wire logic       cke,
  input  wire logic       cmd_des,
  input  wire logic       cmd_nop,
  input  wire logic       odt,
  input  wire logic       banks_open,
  input  wire logic       op_busy,
  input  wire logic       sr_active,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // device state outputs
  output logic            pd_active,
  output logic            pd_precharge,
  output logic            bufs_on,
  output logic            ca_rx_on,
  output logic            odt_buf_on,
  output logic            rtt_nom_on,
  output logic            rtt_park_on,
  output logic            cmd_ok,
  output logic            nop_window
);
  dpd_state_e  st_q, st_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        cke_q;
  logic        busy_q, busy_d;
  logic        pda_q, pda_d, pdp_q, pdp_d;
  logic        bufs_q, bufs_d, carx_q, carx_d, odtb_q, odtb_d;
  logic        nom_q, nom_d, park_q, park_d, ok_q, ok_d, nopw_q, nopw_d;
  dpd_tmr_if   tm ();

  dpd_timer u_tmr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .t        (tm)
  );

  function automatic logic cmd_clean(input logic des, input logic nop);
    cmd_clean = des | nop;
  endfunction

  // timer loads land on the transition edge, so the count starts with the state
  // state sequencing with timer loads
  always_comb begin
    st_d     = st_q;
    busy_d   = busy_q;
    tm.load  = 1'b0;
    tm.value = 4'h0;
    case (st_q)
      DPD_IDLE: begin
        if (!cke && cke_q && cmd_des) begin
          st_d     = DPD_DEACT;
          busy_d   = op_busy;
          tm.load  = 1'b1;
          tm.value = 4'(`DPD_TCPDED);
        // a nop may stand in for the deselect here
        end else if (sr_active && cke && !cke_q && cmd_clean(cmd_des, cmd_nop)) begin
          st_d     = DPD_NOPW;
          tm.load  = 1'b1;
          tm.value = 4'(`DPD_TMPX_LH);
        end
      end
      DPD_DEACT: begin
        if (tm.done) begin
          st_d = DPD_DOWN;
        end
      end
      DPD_DOWN: begin
        busy_d = busy_q & op_busy;
        // exit on CKE high with DES
        if (cke && cmd_clean(cmd_des, 1'b0)) begin
          st_d     = DPD_EXIT;
          tm.load  = 1'b1;
          tm.value = 4'(`DPD_TXP);
        end
      end
      DPD_EXIT: begin
        if (tm.done) begin
          st_d = DPD_IDLE;
        end
      end
      DPD_NOPW: begin
        if (tm.done) begin
          st_d = DPD_IDLE;
        end
      end
      default: st_d = DPD_IDLE;
    endcase
  end

  // built from st_d so every output flips with the state, not a cycle later
  // pin-facing outputs from next state
  always_comb begin
    bufs_d = !(st_d == DPD_DOWN || st_d == DPD_DEACT);
    carx_d = (st_d != DPD_DOWN);
    pda_d  = (st_d == DPD_DOWN) && !busy_d && banks_open;
    pdp_d  = (st_d == DPD_DOWN) && !busy_d && !banks_open;
    odtb_d = !((st_d == DPD_DOWN) && ctrl_q[`DPD_CTRL_ODTOFF]);
    nom_d  = ctrl_q[`DPD_CTRL_NOM] && odtb_d && odt
             && !(ctrl_q[`DPD_CTRL_ODTOFF] && (st_d != DPD_IDLE || !cke));
    park_d = ctrl_q[`DPD_CTRL_PARK];
    ok_d   = (st_d == DPD_IDLE);
    nopw_d = (st_d == DPD_NOPW);
  end

  // register port decode; unmapped reads return zero
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == `DPD_REG_CTRL) begin
      ctrl_d = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        `DPD_REG_CTRL:   rdata_d = ctrl_q;
        `DPD_REG_STATUS: rdata_d = {3'h0, st_q};
        `DPD_REG_CNT:    rdata_d = {6'h00, pda_q, pdp_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= DPD_IDLE;
      ctrl_q     <= `DPD_CTRL_RST;
      rdata_q    <= 8'h00;
      cke_q      <= 1'b1;  // idle level of cke, no false rising edge
      busy_q     <= 1'b0;
      pda_q      <= 1'b0;
      pdp_q      <= 1'b0;
      bufs_q     <= 1'b1;
      carx_q     <= 1'b1;
      odtb_q     <= 1'b1;
      nom_q      <= 1'b0;
      park_q     <= 1'b0;
      ok_q       <= 1'b1;
      nopw_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      ctrl_q     <= ctrl_d;
      rdata_q    <= rdata_d;
      cke_q      <= cke;
      busy_q     <= busy_d;
      pda_q      <= pda_d;
      pdp_q      <= pdp_d;
      bufs_q     <= bufs_d;
      carx_q     <= carx_d;
      odtb_q     <= odtb_d;
      nom_q      <= nom_d;
      park_q     <= park_d;
      ok_q       <= ok_d;
      nopw_q     <= nopw_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign pd_active    = pda_q;
  assign pd_precharge = pdp_q;
  assign bufs_on      = bufs_q;
  assign ca_rx_on     = carx_q;
  assign odt_buf_on   = odtb_q;
  assign rtt_nom_on   = nom_q;
  assign rtt_park_on  = park_q;
  assign cmd_ok       = ok_q;
  assign nop_window   = nopw_q;

  property p_entry;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_IDLE && !cke && cke_q && cmd_des) |=> (st_q == DPD_DEACT);
  endproperty
  a_entry: assert property (p_entry) else $error("entry not taken");
  property p_cpded;
    @(posedge core_clk) disable iff (!rstn)
      $rose(st_q == DPD_DEACT) |-> ca_rx_on [*4];
  endproperty
  a_cpded: assert property (p_cpded) else $error("receivers off early");
  property p_bufs;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN) |-> !bufs_on;
  endproperty
  a_bufs: assert property (p_bufs) else $error("buffers on in power-down");
  property p_mode;
    @(posedge core_clk) disable iff (!rstn)
      !(pd_active && pd_precharge);
  endproperty
  a_mode: assert property (p_mode) else $error("both power-down modes");
  property p_odtb;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN && $past(st_q) == DPD_DOWN && ctrl_q[0]) |-> !odt_buf_on;
  endproperty
  a_odtb: assert property (p_odtb) else $error("odt buffer stays on");
  property p_park;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN && $stable(ctrl_q)) |-> (rtt_park_on == ctrl_q[1]);
  endproperty
  a_park: assert property (p_park) else $error("park lost");
  property p_txp;
    @(posedge core_clk) disable iff (!rstn)
      $rose(st_q == DPD_EXIT) |-> !cmd_ok ##1 !cmd_ok [*5] ##[1:3] cmd_ok;
  endproperty
  a_txp: assert property (p_txp) else $error("exit latency wrong");
  property p_nopw;
    @(posedge core_clk) disable iff (!rstn)
      $rose(st_q == DPD_NOPW) |-> ##[1:10] !nop_window;
  endproperty
  a_nopw: assert property (p_nopw) else $error("nop window unbounded");
  property p_nom;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN && ctrl_q[0]) |=> !rtt_nom_on;
  endproperty
  a_nom: assert property (p_nom) else $error("rtt_nom in disable mode");
  property p_srx;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_IDLE && sr_active && cke && !cke_q && cmd_clean(cmd_des, cmd_nop)) |=> (st_q == DPD_NOPW);
  endproperty
  a_srx: assert property (p_srx) else $error("self refresh exit missed");
  property p_nopw_len;
    @(posedge core_clk) disable iff (!rstn)
      $rose(st_q == DPD_NOPW) |-> nop_window [*7] ##1 !nop_window;
  endproperty
  a_nopw_len: assert property (p_nopw_len) else $error("nop window length wrong");
  property p_carx;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN) |-> !ca_rx_on;
  endproperty
  a_carx: assert property (p_carx) else $error("receivers on in power-down");
  property p_busy;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN && busy_q) |-> !(pd_active || pd_precharge);
  endproperty
  a_busy: assert property (p_busy) else $error("mode shown while op pending");
  property p_exit;
    @(posedge core_clk) disable iff (!rstn)
      (st_q == DPD_DOWN && cke && cmd_des) |=> (st_q == DPD_EXIT);
  endproperty
  a_exit: assert property (p_exit) else $error("exit not taken");
  property p_cmdok;
    @(posedge core_clk) disable iff (!rstn)
      (st_q != DPD_IDLE) |-> !cmd_ok;
  endproperty
  a_cmdok: assert property (p_cmdok) else $error("command allowed too early");
endmodule

//--- hdl/dpd_map.svh
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
// register offsets (word index on the plain port)
`define DPD_REG_CTRL      4'h0
`define DPD_REG_STATUS    4'h1
`define DPD_REG_CNT       4'h2
// control field positions
`define DPD_CTRL_ODTOFF   0
`define DPD_CTRL_PARK     1
`define DPD_CTRL_NOM      2
`define DPD_CTRL_RST      8'h00
// timing in clock cycles of the device clock
`define DPD_TCPDED        4
`define DPD_TCKE          3
`define DPD_TXP           5
`define DPD_TMPX_LH       6
`define DPD_WL            9
`define DPD_CNT_W         4
`endif

//--- hdl/dpd_pkg.sv
package dpd_pkg;
  typedef enum logic [4:0] {
    DPD_IDLE  = 5'h01,
    DPD_DEACT = 5'h02,
    DPD_DOWN  = 5'h04,
    DPD_EXIT  = 5'h08,
    DPD_NOPW  = 5'h10
  } dpd_state_e;
  typedef logic [3:0] dpd_cnt_t;
endpackage

//--- hdl/dpd_tmr_if.sv
`timescale 1ns/1ps
interface dpd_tmr_if;
  logic        load;
  logic [3:0]  value;
  logic        done;
  modport owner (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

//--- hdl/dpd_timer.sv
`timescale 1ns/1ps
module dpd_timer
  import dpd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  dpd_tmr_if.timer t
);
  dpd_cnt_t cnt_q;
  dpd_cnt_t cnt_d;
  // count down to zero after a load
  always_comb begin
    cnt_d = cnt_q;
    if (t.load) begin
      cnt_d = t.value;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign t.done = (cnt_q == 4'h0) && !t.load;
endmodule

//--- tb/dpd_ctl_model.sv
`timescale 1ns/1ps
`include "dpd_map.svh"
// controller side: deselects or nops only, cke moves on request
module dpd_ctl_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // requests from the bench, held until cke moves
  input  wire logic go_down,
  input  wire logic go_up,
  // command choice: nop in place of deselect
  input  wire logic nop_mode,
  // pins towards the device
  output logic      cke,
  output logic      cmd_des,
  output logic      cmd_nop,
  output logic      odt
);
  // longest stay down before a forced exit for owed refreshes
  localparam int unsigned REFI_GUARD = 200;
  logic [7:0] cnt_q;
  // one command kind on every edge, so each cke edge carries it
  assign cmd_des = !nop_mode;
  // nops only while the bench asks for them around self refresh exit
  assign cmd_nop = nop_mode;
  // odt held at a valid level throughout
  assign odt = 1'b1;
  // entry asked only with no burst, mode or calibration work and a locked dll
  // cke level kept at least tCKE before it may move again
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cke   <= 1'b1;
      cnt_q <= 8'h00;
    end else if (!cke && cnt_q == 8'(REFI_GUARD)) begin
      cke   <= 1'b1;
      cnt_q <= 8'h00;
    end else if (go_down && cke && cnt_q >= `DPD_TCKE) begin
      cke   <= 1'b0;
      cnt_q <= 8'h00;
    end else if (go_up && !cke && cnt_q >= `DPD_TCKE) begin
      cke   <= 1'b1;
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

//--- tb/tb_dram_power_down_control.sv
`timescale 1ns/1ps
`include "dpd_map.svh"
module tb_dram_power_down_control;
  typedef struct {logic [7:0] ctrl; logic bk; logic act; logic pre; logic odtb; logic park;
                  logic nom;} dpd_row_s;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       go_down = 1'b0;
  logic       go_up = 1'b0;
  logic       cke, cmd_des, cmd_nop, odt;
  logic       banks_open = 1'b0;
  logic       op_busy = 1'b0;
  logic       sr_active = 1'b0;
  logic       nop_mode = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd_v;
  logic       pd_active, pd_precharge, bufs_on, ca_rx_on, odt_buf_on;
  logic       rtt_nom_on, rtt_park_on, cmd_ok, nop_window;
  int         n_errors = 0;
  int         samples_checked = 0;
  // mode rows: control value, banks open, expected mode, buffer, park and rtt_nom flags
  dpd_row_s   rows [5] = '{'{8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}, '{8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
                           '{8'h02, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}, '{8'h07, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
                           '{8'h04, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1}};
  always #12.5 core_clk = ~core_clk;
  dpd_ctl_model i_ctl (.core_clk(core_clk), .rstn(rstn), .go_down(go_down), .go_up(go_up), .nop_mode(nop_mode),
                       .cke(cke), .cmd_des(cmd_des), .cmd_nop(cmd_nop), .odt(odt));
  // busy and self refresh inputs are driven by the hand-written cases
  dpd_core i_dut (.core_clk(core_clk), .rstn(rstn), .cke(cke), .cmd_des(cmd_des), .cmd_nop(cmd_nop),
                  .odt(odt), .banks_open(banks_open), .op_busy(op_busy), .sr_active(sr_active),
                  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                  .reg_rdata(reg_rdata), .pd_active(pd_active), .pd_precharge(pd_precharge),
                  .bufs_on(bufs_on), .ca_rx_on(ca_rx_on), .odt_buf_on(odt_buf_on), .rtt_nom_on(rtt_nom_on),
                  .rtt_park_on(rtt_park_on), .cmd_ok(cmd_ok), .nop_window(nop_window));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // bounded wait for the model to move cke, then a fixed settle
  task automatic move(input logic lvl, input int n);
    for (int i = 0; i < 20 && cke !== lvl; i++) @(posedge core_clk) #1;
    go_down = 1'b0; go_up = 1'b0;
    chk(8'(cke), 8'(lvl));
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20us n_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(8'({bufs_on, ca_rx_on, odt_buf_on, cmd_ok, pd_active, pd_precharge}), 8'h3c);
    rd(`DPD_REG_CTRL); chk(rd_v, `DPD_CTRL_RST);
    wr(`DPD_REG_STATUS, 8'hff); wr(4'hf, 8'hff); rd(`DPD_REG_CTRL); chk(rd_v, `DPD_CTRL_RST);
    foreach (rows[k]) begin
      wr(`DPD_REG_CTRL, rows[k].ctrl); rd(`DPD_REG_CTRL); chk(rd_v, rows[k].ctrl);
      banks_open <= rows[k].bk;
      go_down <= 1'b1;
      move(1'b0, 2); chk(8'(ca_rx_on), 8'h01);
      repeat (8) @(posedge core_clk) #1;
      chk(8'({ca_rx_on, bufs_on}), 8'h00);
      chk(8'({pd_active, pd_precharge}), 8'({rows[k].act, rows[k].pre}));
      chk(8'(odt_buf_on), 8'(rows[k].odtb));
      chk(8'(rtt_nom_on), 8'(rows[k].nom));
      chk(8'(rtt_park_on), 8'(rows[k].park));
      rd(`DPD_REG_STATUS); chk(rd_v, 8'(dpd_pkg::DPD_DOWN));
      rd(`DPD_REG_CNT); chk(rd_v, 8'({rows[k].act, rows[k].pre}));
      go_up <= 1'b1;
      move(1'b1, 2); chk(8'(cmd_ok), 8'h00);
      repeat (10) @(posedge core_clk) #1;
      chk(8'({cmd_ok, bufs_on, pd_active, pd_precharge}), 8'h0c);
    end
    // a pending row operation holds back the power-down mode
    op_busy <= 1'b1;
    banks_open <= 1'b0;
    go_down <= 1'b1;
    move(1'b0, 10);
    chk(8'({bufs_on, pd_active, pd_precharge}), 8'h00);
    op_busy <= 1'b0;
    repeat (2) @(posedge core_clk) #1;
    chk(8'({pd_active, pd_precharge}), 8'h01);
    go_up <= 1'b1;
    move(1'b1, 10);
    chk(8'({cmd_ok, pd_precharge}), 8'h02);
    // self refresh left with nops only: no power-down entry without a deselect
    sr_active <= 1'b1;
    nop_mode <= 1'b1;
    go_down <= 1'b1;
    move(1'b0, 6);
    rd(`DPD_REG_STATUS); chk(rd_v, 8'(dpd_pkg::DPD_IDLE));
    go_up <= 1'b1;
    move(1'b1, 2);
    chk(8'({nop_window, cmd_ok}), 8'h02);
    repeat (8) @(posedge core_clk) #1;
    chk(8'({nop_window, cmd_ok}), 8'h01);
    sr_active <= 1'b0;
    nop_mode <= 1'b0;
    // reset while powered down leaves power-down at once
    go_down <= 1'b1;
    move(1'b0, 10);
    rstn <= 1'b0;
    #1 chk(8'({pd_active, pd_precharge, bufs_on, cmd_ok}), 8'h03);
    // release again and look at the first edge and the control register
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk) #1;
    chk(8'({bufs_on, ca_rx_on, odt_buf_on, cmd_ok, pd_active, pd_precharge}), 8'h3c);
    rd(`DPD_REG_CTRL); chk(rd_v, `DPD_CTRL_RST);
    finish_test();
  end
endmodule
